// ### dsp_pin_mode_pkg.sv
// Constants, pin layout and state types for the pin-mode multiplexer
// How it works
// (R1) Shared bus pin function fixed only in reset
// (R2) Software switches serial pins to alternate use
// (R3) Interrupt and flag stay active together
// (R4) Masked-in pin low vectors, whoever drives it
// (R5) Mode pins sampled in reset, flags afterwards
// (R6) Memory mode from strap; never changes running
// (R7) Strap low: 14 address, 24 data pins
// (R8) Strap high: 16-pin host bus, A0, D23:8
// (R9) Host drives the four host strobes
// (R10) Host acknowledge open drain, strap-configured
// (R11) Host decodes peripherals from A0 and selects
// (R12) Serial port one: two interrupts, flag in/out
// (R13) Fixed edge/level sense per shared interrupt; code makes PF7 and both serial interrupts configurable
// (R14) Granted bus halts core unless run-while-granted
// (R15) Host holds straps steady throughout reset
package dsp_pin_mode_pkg;
   // Pin group widths
   localparam int ADDR_W = 14;
   localparam int DATA_W = 24;
   localparam int HOST_W = 16;
   localparam int FLAG_W = 8;
   localparam int STRAP_W = 4;
   localparam int SEL_W = 5;
   localparam int SP_W = 5;
   localparam int NUM_IRQ = 6;
   // Strap positions within the mode pins
   localparam int STRAP_HOST = 2;
   localparam int STRAP_ACK = 3;
   // Flag pins that double as interrupt inputs
   localparam int PF_EXT_IRQ_CFG_PIN = 7;
   localparam int PF_LEVEL_IRQ_PIN_ONE = 6;
   localparam int PF_LEVEL_IRQ_PIN_ZERO = 5;
   localparam int PF_EDGE_IRQ_PIN = 4;
   // Serial port one pin positions
   localparam int SP_DRX = 1;
   localparam int SP_DTX = 2;
   localparam int SP_RFS = 3;
   localparam int SP_TFS = 4;
   // Interrupt indices
   localparam int IRQ_ZERO = 0;
   localparam int IRQ_ONE = 1;
   localparam int IRQ_EDGE = 2;
   localparam int IRQ_LVL0 = 3;
   localparam int IRQ_LVL1 = 4;
   localparam int IRQ_CFG = 5;
   // Host-mode meaning of the low data pins
   localparam int D_IWR = 7;
   localparam int D_IRD = 6;
   localparam int D_IAL = 5;
   localparam int D_IS = 4;
   localparam int D_HOST_ACK = 3;
   localparam int HOST_UPPER_D = 8;
   // Reset values: everything released, outputs low except the idle selects
   localparam logic [DATA_W-1:0] DATA_RST = 24'h00_0000;
   localparam logic [DATA_W-1:0] DATA_OFF = 24'hFF_FFFF;
   localparam logic [FLAG_W-1:0] FLAG_OFF = 8'hFF;
   localparam logic [SEL_W-1:0] SEL_IDLE = 5'h1F;
   localparam logic [SP_W-1:0] SP_OFF = 5'h1F;
   localparam logic [NUM_IRQ-1:0] IRQ_RST = 6'h00;
   // Memory operating mode, one-hot
   typedef enum logic [1:0] {
      MODE_FULL = 2'b01,
      MODE_HOST = 2'b10
   } mem_mode_t;
   // Bus ownership, one-hot
   typedef enum logic [1:0] {
      BUS_OWN = 2'b01,
      BUS_GRANTED = 2'b10
   } bus_state_t;
endpackage : dsp_pin_mode_pkg

// ### irq_sense_if.sv
// Interface between the pin multiplexer and the interrupt sense unit
`timescale 1ns/1ps
`default_nettype none
interface irq_sense_if;
   import dsp_pin_mode_pkg::*;
   logic [NUM_IRQ-1:0] pin_low;   // Request pin seen asserted
   logic [NUM_IRQ-1:0] edge_mode; // 1 = falling edge, 0 = level
   logic [NUM_IRQ-1:0] mask;      // Interrupt enable per source
   logic [NUM_IRQ-1:0] clear;     // Core acknowledge of an edge latch
   logic [NUM_IRQ-1:0] pend;      // Masked request to the core
   modport mux_side (output pin_low, edge_mode, mask, clear, input pend);
   modport sense_side (input pin_low, edge_mode, mask, clear, output pend);
endinterface : irq_sense_if
`default_nettype wire

// ### strap_latch.sv
// Mode strap capture held fixed from reset release onward
`timescale 1ns/1ps
`default_nettype none
module strap_latch
   import dsp_pin_mode_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Mode pins as seen at the package
   input wire logic [STRAP_W-1:0] strap_pins,
   // Captured configuration
   output mem_mode_t mem_mode,
   output logic ack_cfg
);
   // Sampled every edge while reset is low, frozen after
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         // Strap level picks the memory mode, see (R5) (R6)
         mem_mode <= strap_pins[STRAP_HOST] ? MODE_HOST : MODE_FULL;
         ack_cfg <= strap_pins[STRAP_ACK];
      end
   end

   // Once running, neither setting may move
   mode_frozen_a: assert property (@(posedge mclk) disable iff (!resetn)
      $past(resetn) |-> $stable(mem_mode) && $stable(ack_cfg)) // see (R1)
      else $error("memory mode changed while running");
endmodule : strap_latch
`default_nettype wire

// ### irq_sense.sv
// Edge or level sensing and masking of the shared interrupt pins
`timescale 1ns/1ps
`default_nettype none
module irq_sense
   import dsp_pin_mode_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Requests from the multiplexer
   irq_sense_if.sense_side irq
);
   logic [NUM_IRQ-1:0] prev_low; // Pin level one edge ago
   logic [NUM_IRQ-1:0] latched;  // Sticky edge captures

   // One detector per source
   for (genvar i = 0; i < NUM_IRQ; i++)
   begin : g_src
      // Edge latch: a new edge beats a clear in the same cycle
      always_ff @(posedge mclk)
      begin
         if (!resetn)
         begin
            prev_low[i] <= 1'b0;
            latched[i] <= 1'b0;
         end
         else
         begin
            prev_low[i] <= irq.pin_low[i];
            if (irq.pin_low[i] && !prev_low[i])
               latched[i] <= 1'b1;
            else if (irq.clear[i])
               latched[i] <= 1'b0;
         end
      end

      // Masked request; level sources track the pin, see (R3) (R13)
      always_ff @(posedge mclk)
      begin
         if (!resetn)
            irq.pend[i] <= 1'b0;
         else if (irq.edge_mode[i])
            irq.pend[i] <= irq.mask[i] && (latched[i] ||
                           (irq.pin_low[i] && !prev_low[i]));
         else
            irq.pend[i] <= irq.mask[i] && irq.pin_low[i]; // see (R4)
      end

      // An edge latch is set only by a fresh assertion
      edge_fresh_a: assert property (@(posedge mclk) disable iff (!resetn)
         irq.edge_mode[i] && $rose(latched[i]) |->
         $past(irq.pin_low[i]) && !$past(prev_low[i])) // see (R13)
         else $error("edge latch set without a falling edge");
   end
endmodule : irq_sense
`default_nettype wire

// ### dsp_pin_mode_mux.sv
// Reset-strapped pin function multiplexer of the signal processor
`timescale 1ns/1ps
`default_nettype none
module dsp_pin_mode_mux
   import dsp_pin_mode_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Flag pins PF7:0; PF3:0 are the mode straps
   input wire logic [FLAG_W-1:0] pf_in,
   output logic [FLAG_W-1:0] pf_out,
   output logic [FLAG_W-1:0] pf_oe_n,
   // Address pins A13:1, also host address/data 12:0
   input wire logic [ADDR_W-2:0] a_hi_in,
   output logic [ADDR_W-2:0] a_hi_out,
   output logic [ADDR_W-2:0] a_hi_oe_n,
   // Lowest address pin, kept in both modes
   output logic low_address_bit,
   output logic low_address_oe_n,
   // Data pins D23:0; D7:0 are host pins in host mode
   input wire logic [DATA_W-1:0] d_in,
   output logic [DATA_W-1:0] d_out,
   output logic [DATA_W-1:0] d_oe_n,
   // Memory selects: combined, program, data, io, byte
   output logic [SEL_W-1:0] mem_select_n,
   output logic mem_select_oe_n,
   // Bus arbitration pins
   input wire logic bus_request_n,
   output logic bus_grant_n,
   output logic bus_grant_hung,
   // Serial port one pins
   input wire logic [SP_W-1:0] sp1_in,
   output logic [SP_W-1:0] sp1_out,
   output logic [SP_W-1:0] sp1_oe_n,
   // Core external memory access
   input wire logic [ADDR_W-1:0] core_addr,
   input wire logic [DATA_W-1:0] core_wdata,
   input wire logic core_data_drive,
   input wire logic [SEL_W-1:0] core_select,
   input wire logic core_ext_pending,
   input wire logic go_mode,
   output logic [DATA_W-1:0] core_rdata,
   output logic core_halt,
   // Internal access port side
   input wire logic [HOST_W-1:0] host_rdata,
   input wire logic host_rdata_drive,
   input wire logic host_ack_ready,
   input wire logic host_ack_done,
   output logic [HOST_W-1:0] host_addr_data_bus,
   output logic host_write_strobe_n,
   output logic host_read_strobe_n,
   output logic host_addr_latch,
   output logic host_select_n,
   // Flags and interrupts from the core
   input wire logic [FLAG_W-1:0] flag_dir,
   input wire logic [FLAG_W-1:0] flag_val,
   input wire logic [NUM_IRQ-1:0] interrupt_mask_reg,
   input wire logic [NUM_IRQ-1:0] irq_clear,
   input wire logic ext_irq_cfg_pin_edge_cfg,
   input wire logic [1:0] irq_sp_edge_cfg,
   output logic [FLAG_W-1:0] flag_seen,
   output logic [NUM_IRQ-1:0] irq_pending,
   // Serial port one engine and its alternate use
   input wire logic serial_port_one_alt_sel,
   input wire logic [SP_W-1:0] serial_core_out,
   input wire logic [SP_W-1:0] serial_core_oe_n,
   input wire logic flag_out,
   output logic [SP_W-1:0] serial_core_in,
   output logic flag_in,
   // Configuration status
   output logic host_mode,
   output logic ack_cfg
);
   mem_mode_t mem_mode;  // Latched memory mode
   bus_state_t bus_st;   // Who owns the external buses
   logic granted;        // Buses handed to another master
   logic ack_assert;     // Acknowledge wanted on the open-drain pin
   logic [ADDR_W-2:0] next_a_out;
   logic [ADDR_W-2:0] next_a_oe_n;
   logic [DATA_W-1:0] next_d_out;
   logic [DATA_W-1:0] next_d_oe_n;
   logic [SP_W-1:0] next_sp_out;
   logic [SP_W-1:0] next_sp_oe_n;
   logic [NUM_IRQ-1:0] own_low; // Own flag driver pulling a pin low

   irq_sense_if irq_bus ();

   // Strap capture; straps must sit still through reset, see (R15)
   strap_latch u_strap (
      .mclk(mclk),
      .resetn(resetn),
      .strap_pins(pf_in[STRAP_W-1:0]),
      .mem_mode(mem_mode),
      .ack_cfg(ack_cfg)
   );

   // Interrupt sense and masking
   irq_sense u_irq (
      .mclk(mclk),
      .resetn(resetn),
      .irq(irq_bus)
   );

   assign host_mode = (mem_mode == MODE_HOST);
   assign granted = (bus_st == BUS_GRANTED);
   assign irq_pending = irq_bus.pend;

   // Own flag drive counts as an assertion too, see (R4)
   assign own_low[IRQ_CFG] = !pf_oe_n[PF_EXT_IRQ_CFG_PIN] && !pf_out[PF_EXT_IRQ_CFG_PIN];
   assign own_low[IRQ_LVL1] = !pf_oe_n[PF_LEVEL_IRQ_PIN_ONE] && !pf_out[PF_LEVEL_IRQ_PIN_ONE];
   assign own_low[IRQ_LVL0] = !pf_oe_n[PF_LEVEL_IRQ_PIN_ZERO] && !pf_out[PF_LEVEL_IRQ_PIN_ZERO];
   assign own_low[IRQ_EDGE] = !pf_oe_n[PF_EDGE_IRQ_PIN] && !pf_out[PF_EDGE_IRQ_PIN];
   assign own_low[IRQ_ONE] = 1'b0;
   assign own_low[IRQ_ZERO] = 1'b0;

   // Interrupt requests; flag function runs alongside, see (R3)
   always_comb
   begin
      irq_bus.pin_low[IRQ_CFG] = !pf_in[PF_EXT_IRQ_CFG_PIN] || own_low[IRQ_CFG];
      irq_bus.pin_low[IRQ_LVL1] = !pf_in[PF_LEVEL_IRQ_PIN_ONE] || own_low[IRQ_LVL1];
      irq_bus.pin_low[IRQ_LVL0] = !pf_in[PF_LEVEL_IRQ_PIN_ZERO] || own_low[IRQ_LVL0];
      irq_bus.pin_low[IRQ_EDGE] = !pf_in[PF_EDGE_IRQ_PIN] || own_low[IRQ_EDGE];
      // Serial pins only interrupt in the alternate use, see (R12)
      irq_bus.pin_low[IRQ_ONE] = serial_port_one_alt_sel && !sp1_in[SP_TFS];
      irq_bus.pin_low[IRQ_ZERO] = serial_port_one_alt_sel && !sp1_in[SP_RFS];
   end

   // Fixed sense per pin; three configurable ones, see (R13)
   assign irq_bus.edge_mode = {ext_irq_cfg_pin_edge_cfg, 1'b0, 1'b0, 1'b1,
                               irq_sp_edge_cfg};
   assign irq_bus.mask = interrupt_mask_reg;
   assign irq_bus.clear = irq_clear;

   // Bus ownership follows the request pin
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         bus_st <= BUS_OWN;
      else
      begin
         unique case (bus_st)
            BUS_OWN:
               if (!bus_request_n)
                  bus_st <= BUS_GRANTED;
            BUS_GRANTED:
               if (bus_request_n)
                  bus_st <= BUS_OWN;
         endcase
      end
   end

   // Grant outputs; core halts unless run-while-granted, see (R14)
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         bus_grant_n <= 1'b1;
         bus_grant_hung <= 1'b0;
         core_halt <= 1'b0;
      end
      else
      begin
         bus_grant_n <= !granted;
         bus_grant_hung <= granted && go_mode && core_ext_pending;
         core_halt <= granted && !go_mode;
      end
   end

   // Acknowledge source picked by the PF3 strap, see (R10)
   assign ack_assert = ack_cfg ? host_ack_done : host_ack_ready;

   // Address and data pin function from the latched mode
   always_comb
   begin
      next_a_out = core_addr[ADDR_W-1:1];
      next_a_oe_n = {(ADDR_W-1){granted}};
      next_d_out = core_wdata;
      next_d_oe_n = {DATA_W{granted || !core_data_drive}};
      unique case (mem_mode)
         MODE_FULL:
         begin
            // Full memory bus, core write data on all of D23:0, see (R7)
         end
         MODE_HOST:
         begin
            // Host bus on A13:1 and D2:0; grant does not touch it
            next_a_out = host_rdata[ADDR_W-2:0]; // see (R8)
            next_a_oe_n = {(ADDR_W-1){!host_rdata_drive || d_in[D_IS]}};
            next_d_out[2:0] = host_rdata[HOST_W-1:ADDR_W-1];
            next_d_oe_n[2:0] = {3{!host_rdata_drive || d_in[D_IS]}};
            // Strobes are inputs from the host, see (R9)
            next_d_out[D_IWR:D_IS] = 4'h0;
            next_d_oe_n[D_IWR:D_IS] = 4'hF;
            // Acknowledge only ever pulls low, see (R10)
            next_d_out[D_HOST_ACK] = 1'b0;
            next_d_oe_n[D_HOST_ACK] = !ack_assert;
         end
      endcase
   end

   // External pin registers
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         a_hi_out <= '0;
         a_hi_oe_n <= '1;
         d_out <= DATA_RST;
         d_oe_n <= DATA_OFF;
         low_address_bit <= 1'b0;
         low_address_oe_n <= 1'b1;
         mem_select_n <= SEL_IDLE;
         mem_select_oe_n <= 1'b1;
      end
      else
      begin
         a_hi_out <= next_a_out;
         a_hi_oe_n <= next_a_oe_n;
         d_out <= next_d_out;
         d_oe_n <= next_d_oe_n;
         // A0 and selects stay for host decoding, see (R8) (R11)
         low_address_bit <= core_addr[0];
         low_address_oe_n <= granted;
         mem_select_n <= ~core_select;
         mem_select_oe_n <= granted;
      end
   end

   // Read-back paths to the core and the access port
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         core_rdata <= DATA_RST;
         host_addr_data_bus <= '0;
         host_write_strobe_n <= 1'b1;
         host_read_strobe_n <= 1'b1;
         host_addr_latch <= 1'b0;
         host_select_n <= 1'b1;
      end
      else
      begin
         core_rdata <= d_in;
         // Host strobes idle outside host mode
         host_addr_data_bus <= host_mode ? {d_in[2:0], a_hi_in} : '0;
         host_write_strobe_n <= !host_mode || d_in[D_IWR];
         host_read_strobe_n <= !host_mode || d_in[D_IRD];
         host_addr_latch <= host_mode && d_in[D_IAL];
         host_select_n <= !host_mode || d_in[D_IS];
      end
   end

   // Flags: released through reset so straps can be read, see (R5)
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         pf_out <= '0;
         pf_oe_n <= FLAG_OFF;
         flag_seen <= '0;
      end
      else
      begin
         pf_out <= flag_val;
         pf_oe_n <= ~flag_dir;
         flag_seen <= pf_in;
      end
   end

   // Serial port one pin use, chosen at run time, see (R2)
   always_comb
   begin
      next_sp_out = serial_core_out;
      next_sp_oe_n = serial_core_oe_n;
      if (serial_port_one_alt_sel)
      begin
         // Frame pins become interrupt inputs, see (R12)
         next_sp_oe_n[SP_RFS] = 1'b1;
         next_sp_oe_n[SP_TFS] = 1'b1;
         next_sp_oe_n[SP_DRX] = 1'b1;
         next_sp_out[SP_DTX] = flag_out;
         next_sp_oe_n[SP_DTX] = 1'b0;
      end
   end

   // Serial pin registers; internal clock still usable in both uses
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         sp1_out <= '0;
         sp1_oe_n <= SP_OFF;
         serial_core_in <= '0;
         flag_in <= 1'b0;
      end
      else
      begin
         sp1_out <= next_sp_out;
         sp1_oe_n <= next_sp_oe_n;
         serial_core_in <= sp1_in;
         flag_in <= serial_port_one_alt_sel && sp1_in[SP_DRX];
      end
   end

   // Mode taken from the strap seen on the last reset edge
   strap_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
      $past(!resetn) |-> host_mode == $past(pf_in[STRAP_HOST])) // see (R6)
      else $error("memory mode does not match strap");

   // Mode pins released on the first edge after reset
   strap_release_a: assert property (@(posedge mclk) disable iff (!resetn)
      $past(!resetn) |-> pf_oe_n == FLAG_OFF) // see (R5)
      else $error("mode pins driven right after reset");

   // Full mode address follows the core one edge later
   full_addr_a: assert property (@(posedge mclk) disable iff (!resetn)
      !host_mode && !granted |=> a_hi_out == $past(core_addr[ADDR_W-1:1])
      && low_address_bit == $past(core_addr[0])) // see (R7)
      else $error("full mode address pins wrong");

   // Host strobes are never driven by the device
   host_strobe_a: assert property (@(posedge mclk) disable iff (!resetn)
      host_mode && $past(resetn) |-> d_oe_n[D_IWR:D_IS] == 4'hF) // see (R9)
      else $error("host strobe pin driven");

   // Acknowledge pulls low only, from the strapped source
   ack_drain_a: assert property (@(posedge mclk) disable iff (!resetn)
      host_mode && (ack_cfg ? host_ack_done : host_ack_ready) |=>
      !d_oe_n[D_HOST_ACK] && !d_out[D_HOST_ACK]) // see (R10)
      else $error("host acknowledge not pulled low");

   // Alternate serial use puts the flag on the transmit pin
   sport_alt_a: assert property (@(posedge mclk) disable iff (!resetn)
      serial_port_one_alt_sel |=> !sp1_oe_n[SP_DTX]
      && sp1_out[SP_DTX] == $past(flag_out)) // see (R2) (R12)
      else $error("alternate flag output missing");

   // Own flag low on a level pin raises its interrupt
   own_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
      own_low[IRQ_LVL1] && interrupt_mask_reg[IRQ_LVL1]
      |=> irq_pending[IRQ_LVL1]) // see (R4)
      else $error("own flag did not raise interrupt");

   // Granted buses: halt and data pins released within two edges
   grant_halt_a: assert property (@(posedge mclk) disable iff (!resetn)
      !bus_request_n && !go_mode && !host_mode ##1 !bus_request_n && !go_mode
      |=> core_halt && d_oe_n == DATA_OFF) // see (R14)
      else $error("core not halted while buses granted");
endmodule : dsp_pin_mode_mux
`default_nettype wire

// ### ext_side_model.sv
// Far-side model: straps, external flag drivers, memory and host lines
`timescale 1ns/1ps
`default_nettype none
module ext_side_model
   import dsp_pin_mode_pkg::*;
(
   // Reset, so the straps are only presented while it is held
   input wire logic resetn,
   // What the far side wants on the lines
   input wire logic [STRAP_W-1:0] strap,
   input wire logic [FLAG_W-1:0] ext_pf,
   input wire logic [DATA_W-1:0] ext_d,
   // What the device drives
   input wire logic [FLAG_W-1:0] pf_out,
   input wire logic [FLAG_W-1:0] pf_oe_n,
   input wire logic [DATA_W-1:0] d_out,
   input wire logic [DATA_W-1:0] d_oe_n,
   // Resolved wire levels
   output logic [FLAG_W-1:0] pf_in,
   output logic [DATA_W-1:0] d_in
);
   logic [FLAG_W-1:0] far_pf; // Far-side flag drive
   logic [DATA_W-1:0] far_d;  // Far-side data drive
   // Straps held steady for the whole reset, flags after it
   assign far_pf = resetn ? ext_pf : {ext_pf[7:4], strap};
   // D7:4 carry host strobes from the host
   // Acknowledge line has only a pull-up out here
   assign far_d = {ext_d[23:4], 1'b1, ext_d[2:0]};
   // Device wins wherever its enable is low
   assign pf_in = (pf_out & ~pf_oe_n) | (far_pf & pf_oe_n);
   assign d_in = (d_out & ~d_oe_n) | (far_d & d_oe_n);
endmodule : ext_side_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the pin-mode multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dsp_pin_mode_pkg::*;
   logic mclk, resetn, bus_request_n, core_data_drive, core_ext_pending;
   logic go_mode, host_rdata_drive, host_ack_ready, host_ack_done;
   logic ext_irq_cfg_pin_edge_cfg, serial_port_one_alt_sel, flag_out, flag_in;
   logic low_address_bit, low_address_oe_n, mem_select_oe_n;
   logic bus_grant_n, bus_grant_hung, core_halt, host_mode, ack_cfg;
   logic host_write_strobe_n, host_read_strobe_n, host_addr_latch;
   logic host_select_n;
   logic [1:0] irq_sp_edge_cfg;
   logic [3:0] strap;
   logic [7:0] pf_in, pf_out, pf_oe_n, flag_dir, flag_val, flag_seen;
   logic [7:0] ext_pf;
   logic [12:0] a_hi_in, a_hi_out, a_hi_oe_n;
   logic [13:0] core_addr;
   logic [15:0] host_rdata, host_addr_data_bus;
   logic [23:0] d_in, d_out, d_oe_n, core_wdata, core_rdata, ext_d, r;
   logic [4:0] mem_select_n, core_select, sp1_in, sp1_out, sp1_oe_n;
   logic [4:0] serial_core_out, serial_core_oe_n, serial_core_in;
   logic [5:0] interrupt_mask_reg, irq_clear, irq_pending;
   int err_total, n_compared, seed, cyc, i, k;
   // Clock at 4 ns
   initial
   begin
      mclk = 0;
      forever #2 mclk = ~mclk;
   end
   // Design and far side
   dsp_pin_mode_mux uut (.*);
   ext_side_model far (.resetn(resetn), .strap(strap), .ext_pf(ext_pf),
      .ext_d(ext_d), .pf_out(pf_out), .pf_oe_n(pf_oe_n), .d_out(d_out),
      .d_oe_n(d_oe_n), .pf_in(pf_in), .d_in(d_in));
   // Verdict and end of run
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   // One compare
   task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk
   // Let an edge land, then look
   task automatic step();
      @(posedge mclk);
      #1;
   endtask : step
   // Bounded wait for one pending bit
   task automatic waitp(int b, logic v);
      for (k = 0; k < 4 && irq_pending[b] !== v; k++)
         step();
      chk("irq_pending", v, irq_pending[b]);
   endtask : waitp
   // Reset for ten cycles with the given straps
   task automatic rst(logic [3:0] s);
      @(posedge mclk);
      resetn <= 0;
      strap <= s;
      repeat (10) @(posedge mclk);
      resetn <= 1;
      @(posedge mclk);
   endtask : rst
   // Hang guard, far above the roughly 125 cycles used
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         err_total++;
         test_done();
      end
   end
   initial
   begin
      seed = 5834;
      resetn = 0; strap = 0; ext_pf = 8'hF0; ext_d = 0; a_hi_in = 0;
      bus_request_n = 1; core_addr = 0; core_wdata = 0; core_select = 0;
      core_data_drive = 0; core_ext_pending = 1; go_mode = 0;
      host_rdata = 0; host_rdata_drive = 0; host_ack_ready = 0;
      host_ack_done = 0; flag_dir = 0; flag_val = 8'hFF; irq_clear = 0;
      interrupt_mask_reg = 6'h3F; ext_irq_cfg_pin_edge_cfg = 0; irq_sp_edge_cfg = 0;
      serial_port_one_alt_sel = 0; serial_core_out = 0; serial_core_oe_n = 5'h1F;
      flag_out = 0; sp1_in = 5'h1F;
      rst(4'h0);
      chk("host_mode", 0, host_mode);
      // Full bus: address, select and write data one edge on
      for (i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         r = $random(seed);
         core_addr <= r[13:0];
         core_select <= r[18:14];
         core_wdata <= r ^ 24'h5A_5A5A;
         core_data_drive <= 1;
         step();
         chk("a_hi_out", r[13:1], a_hi_out);
         chk("low_address_bit", r[0], low_address_bit);
         chk("d_out", r ^ 24'h5A_5A5A, d_out);
         chk("d_oe_n", 24'h00_0000, d_oe_n);
         chk("mem_select_n", {~r[18:14]}, mem_select_n);
      end
      // Read side: memory drives, data comes back one edge on
      @(posedge mclk);
      core_data_drive <= 0;
      for (i = 0; i < 6; i++)
      begin
         @(posedge mclk);
         r = $random(seed);
         ext_d <= r;
         step();
         chk("d_oe_n", 24'hFF_FFFF, d_oe_n);
         chk("core_rdata", r | 24'h00_0008, core_rdata);
      end
      // Strap pins turn flags; mode stays put
      for (i = 0; i < 4; i++)
      begin
         @(posedge mclk);
         r = $random(seed) | 24'h00_0004;
         ext_pf <= {4'hF, r[3:0]};
         step();
         chk("flag_seen", r[3:0], flag_seen[3:0]);
         chk("host_mode", 0, host_mode);
      end
      $display("test full_bus done");
      // Level pin, then own flag on a level pin, then an edge pin
      @(posedge mclk);
      ext_pf[5] <= 0;
      waitp(IRQ_LVL0, 1);
      @(posedge mclk);
      ext_pf[5] <= 1;
      waitp(IRQ_LVL0, 0);
      @(posedge mclk);
      flag_dir[6] <= 1;
      flag_val[6] <= 0;
      waitp(IRQ_LVL1, 1);
      chk("pf_oe_n6", 0, pf_oe_n[6]);
      @(posedge mclk);
      flag_dir[6] <= 0;
      waitp(IRQ_LVL1, 0);
      @(posedge mclk);
      ext_pf[4] <= 0;
      waitp(IRQ_EDGE, 1);
      repeat (3) step();
      chk("edge_latched", 1, irq_pending[IRQ_EDGE]);
      @(posedge mclk);
      irq_clear[IRQ_EDGE] <= 1;
      @(posedge mclk);
      irq_clear[IRQ_EDGE] <= 0;
      waitp(IRQ_EDGE, 0);
      @(posedge mclk);
      ext_pf[4] <= 1;
      interrupt_mask_reg[IRQ_LVL0] <= 0;
      ext_pf[5] <= 0;
      repeat (4) step();
      chk("masked", 0, irq_pending[IRQ_LVL0]);
      @(posedge mclk);
      ext_pf[5] <= 1;
      interrupt_mask_reg <= 6'h3F;
      $display("test irq done");
      // Grant in both execution modes
      for (i = 0; i < 2; i++)
      begin
         @(posedge mclk);
         go_mode <= i[0];
         core_data_drive <= 1;
         bus_request_n <= 0;
         for (k = 0; k < 4 && bus_grant_n !== 0; k++)
            step();
         chk("bus_grant_n", 0, bus_grant_n);
         chk("core_halt", !i[0], core_halt);
         chk("bus_grant_hung", i[0], bus_grant_hung);
         chk("a_hi_oe_n", 13'h1FFF, a_hi_oe_n);
         chk("d_oe_n", 24'hFF_FFFF, d_oe_n);
         chk("sel_oe_n", 1, mem_select_oe_n);
         @(posedge mclk);
         bus_request_n <= 1;
         for (k = 0; k < 4 && bus_grant_n !== 1; k++)
            step();
         chk("bus_grant_n", 1, bus_grant_n);
      end
      $display("test grant done");
      // Serial pins: normal, then alternate use
      @(posedge mclk);
      r = $random(seed);
      serial_core_out <= r[4:0];
      serial_core_oe_n <= r[9:5];
      step();
      chk("sp1_out", r[4:0], sp1_out);
      chk("sp1_oe_n", r[9:5], sp1_oe_n);
      @(posedge mclk);
      serial_port_one_alt_sel <= 1;
      flag_out <= r[10];
      sp1_in <= {3'b111, r[11], 1'b1};
      step();
      chk("sp1_dtx", r[10], sp1_out[SP_DTX]);
      chk("dtx_oe_n", 0, sp1_oe_n[SP_DTX]);
      chk("rfs_oe_n", 1, sp1_oe_n[SP_RFS]);
      chk("flag_in", r[11], flag_in);
      @(posedge mclk);
      sp1_in[SP_RFS] <= 0;
      waitp(IRQ_ZERO, 1);
      @(posedge mclk);
      sp1_in[SP_RFS] <= 1;
      waitp(IRQ_ZERO, 0);
      $display("test serial done");
      // Host layout after a second reset
      r = $random(seed);
      rst({r[0], 3'b100});
      chk("host_mode", 1, host_mode);
      chk("ack_cfg", r[0], ack_cfg);
      for (i = 0; i < 6; i++)
      begin
         @(posedge mclk);
         r = $random(seed) | 24'h00_0010;
         ext_d <= r;
         a_hi_in <= r[23:11];
         core_addr <= r[13:0];
         core_wdata <= ~r;
         step();
         chk("host_bus", {r[2:0], r[23:11]}, host_addr_data_bus);
         chk("host_wr", r[7], host_write_strobe_n);
         chk("host_rd", r[6], host_read_strobe_n);
         chk("host_al", r[5], host_addr_latch);
         chk("host_sel", 1, host_select_n);
         chk("low_address_bit", r[0], low_address_bit);
         chk("d_hi", {~r[23:8]}, d_out[23:8]);
         chk("a_hi_oe_n", 13'h1FFF, a_hi_oe_n);
      end
      @(posedge mclk);
      host_ack_done <= ack_cfg;
      host_ack_ready <= !ack_cfg;
      step();
      chk("ack_oe_n", 0, d_oe_n[D_HOST_ACK]);
      chk("ack_out", 0, d_out[D_HOST_ACK]);
      @(posedge mclk);
      host_ack_done <= !ack_cfg;
      host_ack_ready <= ack_cfg;
      step();
      chk("ack_oe_n", 1, d_oe_n[D_HOST_ACK]);
      @(posedge mclk);
      r = $random(seed);
      ext_d[D_IS] <= 0;
      host_rdata <= r[15:0];
      host_rdata_drive <= 1;
      step();
      chk("iad_oe_n", 13'h0000, a_hi_oe_n);
      chk("iad_lo", r[12:0], a_hi_out);
      chk("iad_hi", r[15:13], d_out[2:0]);
      chk("host_mode", 1, host_mode);
      $display("test host done");
      test_done();
   end
endmodule : tb
`default_nettype wire
